// ==== dir_limit_select.sv ====
// Effective force limit for one direction, purely combinational.
// Assumes settings are held stable by the caller between changes.
`timescale 1ns/10ps
module dir_limit_select
  import force_limit_pkg::*;
(
  input dir_cfg_t cfg,
  input wire logic cmd_limit_en,
  input wire logic [PCT_W-1:0] command_force_limit_value,
  input wire logic [PCT_W-1:0] motor_max_pct,
  output logic [PCT_W-1:0] eff_limit_pct
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Out-of-range settings are held at the top of the range
  function automatic logic [PCT_W-1:0] clip(input logic [PCT_W-1:0] v);
    clip = (v > LIMIT_MAX_PCT) ? LIMIT_MAX_PCT : v;
  endfunction

  function automatic logic [PCT_W-1:0] min2(input logic [PCT_W-1:0] a, input logic [PCT_W-1:0] b);
    min2 = (a < b) ? a : b;
  endfunction

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // Internal limit always applies; each active source can only lower it
  always_comb begin
    eff_limit_pct = clip(cfg.internal_pct);
    if (cfg.ext_alloc && !cfg.ext_in_n) begin
      eff_limit_pct = min2(eff_limit_pct, clip(cfg.external_pct));
    end
    if (cfg.cmd_bit) begin
      eff_limit_pct = min2(eff_limit_pct, clip(cfg.external_pct));
    end
    if (cmd_limit_en) begin
      eff_limit_pct = min2(eff_limit_pct, clip(command_force_limit_value));
    end
    eff_limit_pct = min2(eff_limit_pct, motor_max_pct);
  end

endmodule

// ==== drive_force_limit_select.sv ====
// Force limit selector: clamps the signed force command (percent of
// rated force) to the effective forward and reverse limits.
// Assumes all inputs are synchronous to ref_clk and settings are static
// apart from deliberate changes, which act on the next command.
`timescale 1ns/10ps
module drive_force_limit_select
  import force_limit_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic signed [FORCE_W-1:0] force_cmd,
  input wire logic [PCT_W-1:0] fwd_internal_limit_pct,
  input wire logic [PCT_W-1:0] rev_internal_limit_pct,
  input wire logic [PCT_W-1:0] fwd_external_limit_pct,
  input wire logic [PCT_W-1:0] rev_external_limit_pct,
  input wire logic [PCT_W-1:0] motor_max_pct,
  input wire logic fwd_ext_limit_in_n,
  input wire logic rev_ext_limit_in_n,
  input wire logic fwd_limit_input_alloc,
  input wire logic rev_limit_input_alloc,
  input wire logic clamp_status_output_alloc,
  input wire logic motion_direction_select,
  input wire logic cmd_limit_en,
  input wire logic [PCT_W-1:0] command_force_limit_value,
  input wire logic fwd_cmd_limit_bit,
  input wire logic rev_cmd_limit_bit,
  output logic signed [FORCE_W-1:0] force_out,
  output logic force_clamped_out_n,
  output logic [PCT_W-1:0] fwd_limit_now,
  output logic [PCT_W-1:0] rev_limit_now
);

  // ----------------------------------------------------------------
  // Per-direction limit selection
  // ----------------------------------------------------------------
  dir_cfg_t cfg [2];
  logic [PCT_W-1:0] eff_lim [2];
  logic [PCT_W-1:0] pos_lim;
  logic [PCT_W-1:0] neg_lim;
  logic signed [FORCE_W-1:0] pos_lim_s;
  logic signed [FORCE_W-1:0] neg_lim_s;
  limiter_state_t state_q;
  limiter_state_t state_d;

  // Index 0 is forward, index 1 is reverse
  assign cfg[0] = '{internal_pct: fwd_internal_limit_pct, external_pct: fwd_external_limit_pct,
                    ext_in_n: fwd_ext_limit_in_n, ext_alloc: fwd_limit_input_alloc,
                    cmd_bit: fwd_cmd_limit_bit};
  assign cfg[1] = '{internal_pct: rev_internal_limit_pct, external_pct: rev_external_limit_pct,
                    ext_in_n: rev_ext_limit_in_n, ext_alloc: rev_limit_input_alloc,
                    cmd_bit: rev_cmd_limit_bit};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dir
      dir_limit_select u_sel (
        .cfg(cfg[gi]),
        .cmd_limit_en(cmd_limit_en),
        .command_force_limit_value(command_force_limit_value),
        .motor_max_pct(motor_max_pct),
        .eff_limit_pct(eff_lim[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Direction mapping
  // ----------------------------------------------------------------
  // Select 1 flips which sign of command counts as forward
  assign pos_lim = motion_direction_select ? eff_lim[1] : eff_lim[0];
  assign neg_lim = motion_direction_select ? eff_lim[0] : eff_lim[1];
  assign pos_lim_s = signed'({{(FORCE_W-PCT_W){1'b0}}, pos_lim});
  assign neg_lim_s = signed'({{(FORCE_W-PCT_W){1'b0}}, neg_lim});

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Limits act combinationally so a setting change hits the very next command
  always_comb begin
    state_d = state_q;
    state_d.fwd_lim = eff_lim[0];
    state_d.rev_lim = eff_lim[1];
    state_d.clamped = 1'b0;
    if (force_cmd > pos_lim_s) begin
      state_d.force_out = pos_lim_s;
      state_d.clamped = 1'b1;
    end else if (force_cmd < -neg_lim_s) begin
      state_d.force_out = -neg_lim_s;
      state_d.clamped = 1'b1;
    end else begin
      state_d.force_out = force_cmd;
    end
    // Open (high) unless allocated and clamping
    state_d.clamped_out_n = !(state_d.clamped && clamp_status_output_alloc);
  end

  // State register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flip-flops
  assign force_out = state_q.force_out;
  assign force_clamped_out_n = state_q.clamped_out_n;
  assign fwd_limit_now = state_q.fwd_lim;
  assign rev_limit_now = state_q.rev_lim;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Reference internal-only limits, for comparing against the selectors
  logic [PCT_W-1:0] fwd_int_ref;
  logic [PCT_W-1:0] rev_int_ref;
  logic fwd_src_idle;
  logic rev_src_idle;
  assign fwd_int_ref = (fwd_internal_limit_pct > LIMIT_MAX_PCT) ? LIMIT_MAX_PCT : fwd_internal_limit_pct;
  assign rev_int_ref = (rev_internal_limit_pct > LIMIT_MAX_PCT) ? LIMIT_MAX_PCT : rev_internal_limit_pct;
  assign fwd_src_idle = !cmd_limit_en && !fwd_cmd_limit_bit && motor_max_pct >= LIMIT_MAX_PCT;
  assign rev_src_idle = !cmd_limit_en && !rev_cmd_limit_bit && motor_max_pct >= LIMIT_MAX_PCT;

  property p_pos_clamp;
    @(posedge ref_clk) disable iff (reset)
    (!$past(reset) && $past(force_cmd) > $past(pos_lim_s)) |-> (force_out == $past(pos_lim_s) && state_q.clamped);
  endproperty
  a_pos_clamp: assert property (p_pos_clamp) else $error("positive command not held at limit");

  property p_neg_clamp;
    @(posedge ref_clk) disable iff (reset)
    (!$past(reset) && $past(force_cmd) < -$past(neg_lim_s)) |-> force_out == -$past(neg_lim_s);
  endproperty
  a_neg_clamp: assert property (p_neg_clamp) else $error("negative command not held at limit");

  property p_pass;
    @(posedge ref_clk) disable iff (reset)
    (!$past(reset) && !state_q.clamped) |-> force_out == $past(force_cmd);
  endproperty
  a_pass: assert property (p_pass) else $error("unclamped command altered");

  property p_status;
    @(posedge ref_clk) disable iff (reset)
    (!$past(reset) && $past(clamp_status_output_alloc) && $past(force_cmd) > $past(pos_lim_s)) |->
      !force_clamped_out_n;
  endproperty
  a_status: assert property (p_status) else $error("clamp status not closed while clamping");

  property p_unalloc_status;
    @(posedge ref_clk) disable iff (reset)
    !clamp_status_output_alloc ##1 1'b1 |-> force_clamped_out_n;
  endproperty
  a_unalloc_status: assert property (p_unalloc_status) else $error("status driven while unallocated");

  property p_fwd_ext_on;
    @(posedge ref_clk) disable iff (reset)
    (fwd_limit_input_alloc && !fwd_ext_limit_in_n) |-> (eff_lim[0] <= fwd_int_ref && eff_lim[0] <= fwd_external_limit_pct);
  endproperty
  a_fwd_ext_on: assert property (p_fwd_ext_on) else $error("forward external limit not applied");

  property p_fwd_ext_off;
    @(posedge ref_clk) disable iff (reset)
    ((fwd_ext_limit_in_n || !fwd_limit_input_alloc) && fwd_src_idle) |-> eff_lim[0] == fwd_int_ref;
  endproperty
  a_fwd_ext_off: assert property (p_fwd_ext_off) else $error("forward limit not internal alone");

  property p_rev_ext_on;
    @(posedge ref_clk) disable iff (reset)
    (rev_limit_input_alloc && !rev_ext_limit_in_n) |-> (eff_lim[1] <= rev_int_ref && eff_lim[1] <= rev_external_limit_pct);
  endproperty
  a_rev_ext_on: assert property (p_rev_ext_on) else $error("reverse external limit not applied");

  property p_rev_ext_off;
    @(posedge ref_clk) disable iff (reset)
    ((rev_ext_limit_in_n || !rev_limit_input_alloc) && rev_src_idle) |-> eff_lim[1] == rev_int_ref;
  endproperty
  a_rev_ext_off: assert property (p_rev_ext_off) else $error("reverse limit not internal alone");

  property p_motor_max;
    @(posedge ref_clk) disable iff (reset)
    1'b1 |=> (fwd_limit_now <= $past(motor_max_pct) && rev_limit_now <= $past(motor_max_pct));
  endproperty
  a_motor_max: assert property (p_motor_max) else $error("limit above motor maximum");

  property p_dir_map;
    @(posedge ref_clk) disable iff (reset)
    (!motion_direction_select && force_cmd > signed'({6'h00, eff_lim[0]})) |=>
      force_out == signed'({6'h00, $past(eff_lim[0])});
  endproperty
  a_dir_map: assert property (p_dir_map) else $error("direction mapping wrong");

  property p_rev_dir_map;
    @(posedge ref_clk) disable iff (reset)
    (motion_direction_select && force_cmd > signed'({6'h00, eff_lim[1]})) |=>
      force_out == signed'({6'h00, $past(eff_lim[1])});
  endproperty
  a_rev_dir_map: assert property (p_rev_dir_map) else $error("swapped direction uses wrong limit");

  // Status must follow both signs of clamping, and stay open otherwise
  property p_neg_status;
    @(posedge ref_clk) disable iff (reset)
    (!$past(reset) && $past(clamp_status_output_alloc) && $past(force_cmd) < -$past(neg_lim_s)) |->
      !force_clamped_out_n;
  endproperty
  a_neg_status: assert property (p_neg_status) else $error("clamp status not closed on negative clamp");

  property p_open_status;
    @(posedge ref_clk) disable iff (reset)
    (!$past(reset) && $past(force_cmd) <= $past(pos_lim_s) && $past(force_cmd) >= -$past(neg_lim_s)) |->
      force_clamped_out_n;
  endproperty
  a_open_status: assert property (p_open_status) else $error("clamp status closed without clamping");

  // Extra sources may only lower the limit, never raise it
  property p_int_cap;
    @(posedge ref_clk) disable iff (reset)
    1'b1 |-> (eff_lim[0] <= fwd_int_ref && eff_lim[1] <= rev_int_ref);
  endproperty
  a_int_cap: assert property (p_int_cap) else $error("limit above internal setting");

  property p_cmd_limit;
    @(posedge ref_clk) disable iff (reset)
    cmd_limit_en |-> (eff_lim[0] <= command_force_limit_value && eff_lim[1] <= command_force_limit_value);
  endproperty
  a_cmd_limit: assert property (p_cmd_limit) else $error("command limit value not applied");

  property p_cmd_bits;
    @(posedge ref_clk) disable iff (reset)
    (fwd_cmd_limit_bit || rev_cmd_limit_bit) |->
      ((!fwd_cmd_limit_bit || eff_lim[0] <= fwd_external_limit_pct) &&
       (!rev_cmd_limit_bit || eff_lim[1] <= rev_external_limit_pct));
  endproperty
  a_cmd_bits: assert property (p_cmd_bits) else $error("command limit bit not applied");

endmodule

// ==== force_limit_pkg.sv ====
// Constants, carrier types and reset values for the force limit selector.
// Assumes one clock domain; all settings arrive as plain synchronous ports.
//
// How it works
// - Four limit sources: internal, external, command, bits.
// - Limits above motor maximum use motor maximum.
// - Forward internal limit 0..800%, default 30, immediate.
// - Reverse internal limit same, reverse direction only.
// - All limit settings are percent of rated force.
// - Forward input closed: smaller of internal, external.
// - Forward input open: forward internal limit only.
// - Reverse input closed: smaller of internal, external.
// - Reverse input open: reverse internal limit only.
// - External limits 0..800%, default 100, immediate.
// - Limit inputs ignored unless allocated to pins.
// - Clamp status closed while force is clamped.
// - Clamp status appears only once allocated.
// - Direction select 0: count-up is forward.
package force_limit_pkg;

  // ----------------------------------------------------------------
  // Widths and limits
  // ----------------------------------------------------------------
  localparam int PCT_W = 10;
  localparam int FORCE_W = 16;
  localparam logic [PCT_W-1:0] LIMIT_MAX_PCT = 10'h320;     // 800 %
  localparam logic [PCT_W-1:0] INT_LIMIT_DEFAULT = 10'h01E; // 30 %
  localparam logic [PCT_W-1:0] EXT_LIMIT_DEFAULT = 10'h064; // 100 %, host side default
  localparam logic [FORCE_W-1:0] FORCE_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // The per-direction settings one direction needs to pick its limit
  typedef struct packed {
    logic [PCT_W-1:0] internal_pct;
    logic [PCT_W-1:0] external_pct;
    logic ext_in_n;
    logic ext_alloc;
    logic cmd_bit;
  } dir_cfg_t;

  typedef struct packed {
    logic [FORCE_W-1:0] force_out;
    logic clamped;
    logic clamped_out_n;
    logic [PCT_W-1:0] fwd_lim;
    logic [PCT_W-1:0] rev_lim;
  } limiter_state_t;

  localparam limiter_state_t STATE_RST = '{
    force_out: FORCE_RST,
    clamped: 1'b0,
    clamped_out_n: 1'b1,
    fwd_lim: INT_LIMIT_DEFAULT,
    rev_lim: INT_LIMIT_DEFAULT
  };

endpackage

// ==== host_ctrl_model.sv ====
// Host controller seen from the limit selector: drives the two limit inputs
// and watches the clamp status. Assumes requests arrive shortly after ref_clk.
`timescale 1ns/10ps
module host_ctrl_model
  import force_limit_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic want_fwd,
  input wire logic want_rev,
  input wire logic force_clamped_out_n,
  output logic fwd_ext_limit_in_n,
  output logic rev_ext_limit_in_n,
  output int clamp_cycles
);
  // ------------------------------------------------------------
  // Limit inputs, closed (low) for as long as reduced force is wanted
  // ------------------------------------------------------------
  assign fwd_ext_limit_in_n = ~want_fwd;
  assign rev_ext_limit_in_n = ~want_rev;

  // Count of cycles the drive reported clamping, read back by the bench
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clamp_cycles <= 0;
    end else if (force_clamped_out_n == 1'b0) begin
      clamp_cycles <= clamp_cycles + 1;
    end
  end
endmodule

// ==== tb_drive_force_limit_select.sv ====
// Self-checking bench for the force limit selector with an integer model.
// Assumes the package and the host controller model are compiled first.
`timescale 1ns/10ps
module tb_drive_force_limit_select;
  import force_limit_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic signed [FORCE_W-1:0] force_cmd = 16'h0000, force_out;
  logic [PCT_W-1:0] fip = 10'h01E, rip = 10'h01E, fep = 10'h064, rep = 10'h064, mmax = 10'h320, cval = 10'h320;
  logic [PCT_W-1:0] fwd_limit_now, rev_limit_now;
  logic f_alloc = 1'b1, r_alloc = 1'b1, s_alloc = 1'b1, dir = 1'b0, cen = 1'b0, fbit = 1'b0, rbit = 1'b0;
  logic want_fwd = 1'b0, want_rev = 1'b0, f_in_n, r_in_n, force_clamped_out_n, e_n;
  int seed = 68, fail_count = 0, comparisons = 0, cycles = 0, clamp_cycles, exp_clamps = 0;
  int e_force, e_fl, e_rl, lf, lr, p, n;
  int cmds [4];

  drive_force_limit_select drive_force_limit_select_inst (.ref_clk(ref_clk), .reset(reset),
    .force_cmd(force_cmd), .fwd_internal_limit_pct(fip), .rev_internal_limit_pct(rip),
    .fwd_external_limit_pct(fep), .rev_external_limit_pct(rep), .motor_max_pct(mmax),
    .fwd_ext_limit_in_n(f_in_n), .rev_ext_limit_in_n(r_in_n), .fwd_limit_input_alloc(f_alloc),
    .rev_limit_input_alloc(r_alloc), .clamp_status_output_alloc(s_alloc), .motion_direction_select(dir),
    .cmd_limit_en(cen), .command_force_limit_value(cval), .fwd_cmd_limit_bit(fbit), .rev_cmd_limit_bit(rbit),
    .force_out(force_out), .force_clamped_out_n(force_clamped_out_n), .fwd_limit_now(fwd_limit_now),
    .rev_limit_now(rev_limit_now));
  host_ctrl_model host_ctrl_model_inst (.ref_clk(ref_clk), .reset(reset), .want_fwd(want_fwd),
    .want_rev(want_rev), .force_clamped_out_n(force_clamped_out_n), .fwd_ext_limit_in_n(f_in_n),
    .rev_ext_limit_in_n(r_in_n), .clamp_cycles(clamp_cycles));

  // ------------------------------------------------------------
  // Clock and hang guard, ceiling well above the ~840 cycles of tests
  // ------------------------------------------------------------
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [FORCE_W-1:0] seen, input logic [FORCE_W-1:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // ------------------------------------------------------------
  // Integer model; settings above 800 saturate, motor max caps all
  // ------------------------------------------------------------
  function automatic int mn(int a, int b);
    return (a < b) ? a : b;
  endfunction
  function automatic int clip(int v);
    return mn(v, 800);
  endfunction
  function automatic int eff(int ip, int ep, logic use_ext);
    int m;
    m = clip(ip);
    if (use_ext) m = mn(m, clip(ep));
    if (cen) m = mn(m, clip(cval));
    return mn(m, mmax);
  endfunction

  // Expected result of the inputs now applied, due after the next edge
  task automatic expect_next;
    int c;
    logic clamped;
    e_fl = eff(fip, fep, (f_alloc && want_fwd) || fbit);
    e_rl = eff(rip, rep, (r_alloc && want_rev) || rbit);
    p = dir ? e_rl : e_fl;
    n = dir ? e_fl : e_rl;
    c = force_cmd;
    clamped = (c > p) || (c < -n);
    e_force = (c > p) ? p : ((c < -n) ? -n : c);
    e_n = !(clamped && s_alloc);
  endtask

  // One edge later, every registered output against the model
  task automatic cycle_check;
    @(posedge ref_clk);
    #1;
    if (!e_n) exp_clamps++;
    check(force_out, e_force[15:0], "force_out");
    check({15'h0000, force_clamped_out_n}, {15'h0000, e_n}, "status");
    check({6'h00, fwd_limit_now}, e_fl[15:0], "fwd limit");
    check({6'h00, rev_limit_now}, e_rl[15:0], "rev limit");
  endtask

  task automatic in_reset;
    e_force = 0;
    e_n = 1'b1;
    e_fl = 30;
    e_rl = 30;
    cycle_check();
  endtask

  initial begin
    repeat (11) @(posedge ref_clk);
    in_reset();
    reset = 1'b0;
    force_cmd = 16'sd500;
    expect_next();
    cycle_check();
    $display("test reset_defaults done");
    // Boundaries of both signs, both directions, limit inputs on, on but unallocated
    for (int e = 0; e < 3; e++) begin
      for (int d = 0; d < 2; d++) begin
        for (int k = 0; k < 4; k++) begin
          {fip, rip, fep, rep, mmax, cen, fbit, rbit} = {10'h0C8, 10'h096, 10'h032, 10'h03C, 10'h384, 3'b000};
          {want_fwd, want_rev} = (e > 0) ? 2'b11 : 2'b00;
          {f_alloc, r_alloc} = (e == 2) ? 2'b00 : 2'b11;
          dir = d[0];
          lf = (e == 1) ? 50 : 200;
          lr = (e == 1) ? 60 : 150;
          p = d ? lr : lf;
          n = d ? lf : lr;
          cmds = '{p, p + 1, -n, -n - 1};
          force_cmd = 16'(cmds[k]);
          expect_next();
          cycle_check();
        end
      end
    end
    $display("test boundaries done");
    // Random settings, sources and commands, back to back every cycle
    for (int i = 0; i < 800; i++) begin
      force_cmd = 16'($random(seed) % 1200);
      {fip, rip, fep, rep} = {10'($random(seed)), 10'($random(seed)), 10'($random(seed)), 10'($random(seed))};
      {mmax, cval} = {10'($random(seed)), 10'($random(seed))};
      {f_alloc, r_alloc, s_alloc, dir, cen, fbit, rbit, want_fwd, want_rev} = 9'($random(seed));
      expect_next();
      cycle_check();
    end
    // Host counter restarts with reset, so compare it before the mid-run reset
    check(16'(clamp_cycles), 16'(exp_clamps - (e_n ? 0 : 1)), "host clamp count");
    $display("test random done");
    reset = 1'b1;
    in_reset();
    reset = 1'b0;
    expect_next();
    cycle_check();
    $display("test midrun_reset done");
    final_report();
  end
endmodule
